// file: inc/fps_pkg.sv
// Constants, register layouts and state types for the JTAG flash programming port
// How it works
// - Write mode 0000: a data write only replaces the byte, no flash action.
// - Write mode 0001: a data write programs the byte, then address increments.
// - Write mode 0010: a data write of 0xA5 erases the addressed page.
// - Erase keeps the address; addresses 0x7DFE and 0x7DFF erase all user space.
// - Read mode 0000: a data read returns contents, no flash action.
// - Read mode 0001: each data read starts a byte read when idle.
// - Read mode 0010: read starts only when idle and prior data was read out.
// - Data register: byte in bits 9:2, fail in bit 1, pending in bit 0.
// - Fail flag is 1 after a failed flash operation, 0 after success.
// - Pending flag is 1 during an operation; data accesses then start nothing.
// - Read strobe lasts one clock, or two clocks (50 ns rounded up to 80 ns) with the one-shot bit set.
// - Output and sense enables follow reads, or stay on with read-always set.
// - Scale bits 5 and 4 read zero and ignore writes.
// - Prescaler value 1111b refuses every flash read, program and erase.
// - Commands carry an op code in bits 19:18: 0x poll, 10 read, 11 write.
// - Outgoing word has busy at bit 0; read and write while busy are ignored.
// - A poll captures status and updates no register.
package fps_pkg;
  // Instruction register
  localparam int IR_LEN = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET_CODE = 4'hF;
  localparam logic [3:0] IR_SEL_CONTROL = 4'h4;
  localparam logic [3:0] IR_SEL_ADDRESS = 4'h5;
  localparam logic [3:0] IR_SEL_DATA = 4'h6;
  localparam logic [3:0] IR_SEL_SCALE = 4'h7;
  // Indirect command word
  localparam int CMD_LEN = 20;
  localparam int OP_HI = 19;
  localparam int OP_LO = 18;
  localparam int VAL_W = 18;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;
  // Mode control fields
  localparam int WMODE_HI = 7;
  localparam int WMODE_LO = 4;
  localparam int RMODE_HI = 3;
  localparam int RMODE_LO = 0;
  localparam logic [3:0] WMODE_PROGRAM = 4'h1;
  localparam logic [3:0] WMODE_ERASE = 4'h2;
  localparam logic [3:0] RMODE_BLOCK = 4'h1;
  localparam logic [3:0] RMODE_SINGLE = 4'h2;
  localparam logic [7:0] ERASE_KEY = 8'hA5;
  // Address space
  localparam int ADDR_W = 15;
  localparam logic [14:0] ERASE_ALL_LO = 15'h7DFE;
  localparam logic [14:0] ERASE_ALL_HI = 15'h7DFF;
  // Data register layout
  localparam int DAT_W = 10;
  localparam int DAT_BYTE_HI = 9;
  localparam int DAT_BYTE_LO = 2;
  localparam int DAT_FAIL_BIT = 1;
  localparam int DAT_BUSY_BIT = 0;
  // Scale register layout
  localparam int ONE_SHOT_BIT = 7;
  localparam int READ_ALWAYS_BIT = 6;
  localparam int PRESCALE_HI = 3;
  localparam int PRESCALE_LO = 0;
  localparam logic [3:0] PRESCALE_LOCKED = 4'hF;
  localparam logic [7:0] SCALE_WMASK = 8'hCF;
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] SCALE_RST = 8'h00;
  localparam logic [7:0] DATA_BYTE_RST = 8'h00;
  localparam logic [14:0] ADDR_RST = 15'h0000;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int ONE_SHOT_NS = 50;
  localparam logic [1:0] FULL_STROBE_CYCLES = 2'h1;
  localparam logic [1:0] ONE_SHOT_CYCLES =
    2'((ONE_SHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PROG_TICKS_DEF = 8'h04;
  localparam logic [7:0] ERASE_TICKS_DEF = 8'h28;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4, TAP_EXIT1_DR = 4'h5, TAP_PAUSE_DR = 4'h6, TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC, TAP_PAUSE_IR = 4'hD, TAP_EXIT2_IR = 4'hE, TAP_UPD_IR = 4'hF
  } fps_tap_t;

  typedef enum logic [1:0] {
    OP_IDLE = 2'h0, OP_READING = 2'h1, OP_PROGRAM = 2'h2, OP_ERASING = 2'h3
  } fps_op_t;
endpackage

// file: verilog/fps_op_timer.sv
// Prescaled duration timer for flash program and erase cycles
`timescale 1ns/1ps
module fps_op_timer (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [3:0] prescale_i,
  input wire logic [7:0] ticks_i,
  output logic done_o
);
  logic [15:0] div_reg;
  logic [7:0] tick_reg;
  logic run_reg;
  logic wrap;

  // One tick every 2^prescale clocks
  assign wrap = (div_reg == 16'((17'h1 << prescale_i) - 17'h1));

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_reg <= 16'h0000;
      tick_reg <= 8'h00;
      run_reg <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        div_reg <= 16'h0000;
        tick_reg <= (ticks_i == 8'h00) ? 8'h01 : ticks_i;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        div_reg <= wrap ? 16'h0000 : div_reg + 16'h0001;
        if (wrap) begin
          tick_reg <= tick_reg - 8'h01;
          if (tick_reg == 8'h01) begin
            run_reg <= 1'b0;
            done_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// file: verilog/fps_jtag_flash_port.sv
// JTAG indirect register port and flash sequencer, split over test and system clocks
`timescale 1ns/1ps
module fps_jtag_flash_port #(
  parameter logic [7:0] PROG_TICKS = fps_pkg::PROG_TICKS_DEF,
  parameter logic [7:0] ERASE_TICKS = fps_pkg::ERASE_TICKS_DEF
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [7:0] flash_rdata_i,
  input wire logic flash_locked_i,
  output logic [fps_pkg::ADDR_W-1:0] flash_addr_o,
  output logic [7:0] flash_wdata_o,
  output logic flash_read_strobe_o,
  output logic flash_oe_o,
  output logic flash_sense_en_o,
  output logic flash_prog_o,
  output logic flash_erase_o,
  output logic flash_erase_all_o
);
  import fps_pkg::*;

  function automatic logic is_indirect(input logic [3:0] ir);
    is_indirect = (ir == IR_SEL_CONTROL) || (ir == IR_SEL_ADDRESS) ||
                  (ir == IR_SEL_DATA) || (ir == IR_SEL_SCALE);
  endfunction

  // ---------------- Test clock domain ----------------
  fps_tap_t tap_reg;
  fps_tap_t tap_next;
  logic [3:0] ir_shift_reg;
  logic [3:0] ir_reg;
  logic [CMD_LEN-1:0] dr_shift_reg;
  logic bypass_reg;
  logic [CMD_LEN-1:0] cmd_reg;
  logic [3:0] cmd_ir_reg;
  logic req_tgl_reg;
  logic ack_meta_reg;
  logic ack_sync_reg;
  logic ack_tgl_reg;
  logic link_busy;
  logic [VAL_W-1:0] result_reg;

  // Busy while a command has not yet been answered by the system side
  assign link_busy = req_tgl_reg ^ ack_sync_reg;

  // Standard TAP walk on TMS
  always_comb begin
    case (tap_reg)
      TAP_RESET: tap_next = tms_i ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_next = tms_i ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms_i ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_next = tms_i ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  end

  always_ff @(posedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tap_reg <= TAP_RESET;
    end else begin
      tap_reg <= tap_next;
    end
  end

  // Instruction register; unknown codes fall through to bypass
  always_ff @(posedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ir_shift_reg <= IR_CAPTURE;
      ir_reg <= IR_RESET_CODE;
    end else begin
      case (tap_reg)
        TAP_RESET: ir_reg <= IR_RESET_CODE;
        TAP_CAP_IR: ir_shift_reg <= IR_CAPTURE;
        TAP_SHIFT_IR: ir_shift_reg <= {tdi_i, ir_shift_reg[IR_LEN-1:1]};
        TAP_UPD_IR: ir_reg <= ir_shift_reg;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Data shift path; host bits enter at the top so short shifts stay left-justified
  always_ff @(posedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dr_shift_reg <= '0;
      bypass_reg <= 1'b0;
    end else begin
      if (tap_reg == TAP_CAP_DR) begin
        // Read value masked while busy, it may still be in flight
        dr_shift_reg <= {1'b0, (link_busy ? {VAL_W{1'b0}} : result_reg), link_busy};
        bypass_reg <= 1'b0;
      end else if (tap_reg == TAP_SHIFT_DR) begin
        dr_shift_reg <= {tdi_i, dr_shift_reg[CMD_LEN-1:1]};
        bypass_reg <= tdi_i;
      end
    end
  end

  // Read and write commands latch and raise the request toggle
  always_ff @(posedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_reg <= '0;
      cmd_ir_reg <= IR_RESET_CODE;
      req_tgl_reg <= 1'b0;
    end else if (tap_reg == TAP_UPD_DR && is_indirect(ir_reg) && !link_busy &&
                 dr_shift_reg[OP_HI]) begin
      cmd_reg <= dr_shift_reg;
      cmd_ir_reg <= ir_reg;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end

  // Acknowledge toggle crossing back from the system clock
  always_ff @(posedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
    end
  end

  // Output changes on the falling edge so the host samples a settled bit
  always_ff @(negedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_oe_o <= (tap_reg == TAP_SHIFT_DR) || (tap_reg == TAP_SHIFT_IR);
      if (tap_reg == TAP_SHIFT_IR) begin
        tdo_o <= ir_shift_reg[0];
      end else if (is_indirect(ir_reg)) begin
        tdo_o <= dr_shift_reg[0];
      end else begin
        tdo_o <= bypass_reg;
      end
    end
  end

  // ---------------- System clock domain ----------------
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;
  logic new_cmd;
  logic [1:0] cmd_op;
  logic [VAL_W-1:0] cmd_val;
  logic [7:0] control_reg;
  logic [7:0] scale_reg;
  logic [7:0] byte_reg;
  logic fail_reg;
  logic unread_reg;
  fps_op_t op_reg;
  logic [1:0] strobe_cnt_reg;
  logic timer_start_reg;
  logic timer_done;
  logic [3:0] wmode;
  logic [3:0] rmode;
  logic [3:0] prescale;
  logic pending;
  logic data_read;
  logic data_write;
  logic start_read;
  logic start_prog;
  logic start_erase;
  logic refused;
  logic read_done;
  logic [DAT_W-1:0] data_status;

  assign wmode = control_reg[WMODE_HI:WMODE_LO];
  assign rmode = control_reg[RMODE_HI:RMODE_LO];
  assign prescale = scale_reg[PRESCALE_HI:PRESCALE_LO];
  assign pending = (op_reg != OP_IDLE);
  assign new_cmd = req_sync_reg ^ req_seen_reg;
  // Command word is stable here: it only changes after our acknowledge
  assign cmd_op = cmd_reg[OP_HI:OP_LO];
  assign cmd_val = cmd_reg[VAL_W-1:0];
  assign data_read = new_cmd && cmd_ir_reg == IR_SEL_DATA && cmd_op == OP_READ;
  assign data_write = new_cmd && cmd_ir_reg == IR_SEL_DATA && cmd_op == OP_WRITE;
  assign data_status = {byte_reg, fail_reg, pending};

  // Flash starts; nothing starts while an operation is pending
  assign start_read = data_read && !pending &&
    ((rmode == RMODE_BLOCK) || (rmode == RMODE_SINGLE && !unread_reg));
  assign start_prog = data_write && !pending && wmode == WMODE_PROGRAM;
  assign start_erase = data_write && !pending && wmode == WMODE_ERASE &&
                       cmd_val[VAL_W-1 -: 8] == ERASE_KEY;
  assign refused = prescale == PRESCALE_LOCKED;
  assign read_done = (op_reg == OP_READING) && (strobe_cnt_reg == 2'h1);

  // Request toggle crossing in from the test clock
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
      req_seen_reg <= req_sync_reg;
    end
  end

  // Answer word is written on the same edge as the acknowledge toggle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_tgl_reg <= 1'b0;
      result_reg <= '0;
    end else if (new_cmd) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      if (cmd_op == OP_READ) begin
        // Right-justified read values
        case (cmd_ir_reg)
          IR_SEL_CONTROL: result_reg <= {10'h000, control_reg};
          IR_SEL_ADDRESS: result_reg <= {3'h0, flash_addr_o};
          IR_SEL_DATA: result_reg <= {8'h00, data_status};
          IR_SEL_SCALE: result_reg <= {10'h000, scale_reg};
          default: result_reg <= '0;
        endcase
      end
    end
  end

  // Control and scale writes take the left-justified top byte
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      control_reg <= CONTROL_RST;
      scale_reg <= SCALE_RST;
    end else if (new_cmd && cmd_op == OP_WRITE) begin
      if (cmd_ir_reg == IR_SEL_CONTROL) begin
        control_reg <= cmd_val[VAL_W-1 -: 8];
      end
      if (cmd_ir_reg == IR_SEL_SCALE) begin
        scale_reg <= cmd_val[VAL_W-1 -: 8] & SCALE_WMASK;
      end
    end
  end

  // Data byte: host writes when idle, flash reads load it
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_reg <= DATA_BYTE_RST;
    end else if (read_done) begin
      byte_reg <= flash_rdata_i;
    end else if (data_write && !pending) begin
      byte_reg <= cmd_val[VAL_W-1 -: 8];
    end
  end

  // Unread-data flag; a finished read wins over a clearing host read
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unread_reg <= 1'b0;
    end else if (read_done) begin
      unread_reg <= 1'b1;
    end else if (data_read) begin
      unread_reg <= 1'b0;
    end
  end

  // Target address: host writes, increments after program and block read
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_addr_o <= ADDR_RST;
    end else if (op_reg == OP_PROGRAM && timer_done) begin
      flash_addr_o <= flash_addr_o + 15'h0001;
    end else if (read_done && rmode == RMODE_BLOCK) begin
      flash_addr_o <= flash_addr_o + 15'h0001;
    end else if (new_cmd && cmd_op == OP_WRITE && cmd_ir_reg == IR_SEL_ADDRESS &&
                 !pending) begin
      flash_addr_o <= cmd_val[VAL_W-1 -: ADDR_W];
    end
  end

  // Operation sequencer; erase never touches the address
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      op_reg <= OP_IDLE;
      fail_reg <= 1'b0;
      strobe_cnt_reg <= 2'h0;
      timer_start_reg <= 1'b0;
      flash_read_strobe_o <= 1'b0;
      flash_prog_o <= 1'b0;
      flash_erase_o <= 1'b0;
      flash_erase_all_o <= 1'b0;
      flash_wdata_o <= 8'h00;
    end else begin
      timer_start_reg <= 1'b0;
      case (op_reg)
        OP_IDLE: begin
          if ((start_read || start_prog || start_erase) && refused) begin
            fail_reg <= 1'b1;
          end else if (start_read) begin
            op_reg <= OP_READING;
            flash_read_strobe_o <= 1'b1;
            // Short strobe or one-shot stretch
            strobe_cnt_reg <= scale_reg[ONE_SHOT_BIT] ? ONE_SHOT_CYCLES : FULL_STROBE_CYCLES;
          end else if (start_prog) begin
            op_reg <= OP_PROGRAM;
            fail_reg <= flash_locked_i;
            flash_prog_o <= !flash_locked_i;
            flash_wdata_o <= cmd_val[VAL_W-1 -: 8];
            timer_start_reg <= 1'b1;
          end else if (start_erase) begin
            op_reg <= OP_ERASING;
            fail_reg <= flash_locked_i;
            flash_erase_o <= !flash_locked_i;
            // Top two user bytes select whole user-space erase
            flash_erase_all_o <= !flash_locked_i &&
              (flash_addr_o == ERASE_ALL_LO || flash_addr_o == ERASE_ALL_HI);
            timer_start_reg <= 1'b1;
          end
        end
        OP_READING: begin
          strobe_cnt_reg <= strobe_cnt_reg - 2'h1;
          if (read_done) begin
            op_reg <= OP_IDLE;
            fail_reg <= 1'b0;
            flash_read_strobe_o <= 1'b0;
          end
        end
        OP_PROGRAM, OP_ERASING: begin
          if (timer_done) begin
            op_reg <= OP_IDLE;
            flash_prog_o <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_erase_all_o <= 1'b0;
          end
        end
        default: op_reg <= OP_IDLE;
      endcase
    end
  end

  // Enables rise and fall on the same edges as the strobe; read-always keeps them on for quieter supply
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flash_oe_o <= 1'b0;
      flash_sense_en_o <= 1'b0;
    end else begin
      flash_oe_o <= scale_reg[READ_ALWAYS_BIT] || (start_read && !refused) ||
                    (op_reg == OP_READING && !read_done);
      flash_sense_en_o <= scale_reg[READ_ALWAYS_BIT] || (start_read && !refused) ||
                          (op_reg == OP_READING && !read_done);
    end
  end

  // Program and erase durations scale with the prescaler
  fps_op_timer u_timer (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(timer_start_reg),
    .prescale_i(prescale),
    .ticks_i(op_reg == OP_ERASING ? ERASE_TICKS : PROG_TICKS),
    .done_o(timer_done)
  );
endmodule

// file: verilog/fps_unused_placeholder_none.sv
// Intentionally empty compile unit
`timescale 1ns/1ps

// file: sim/fps_port_sva.sv
// Checker on the flash-side pins of the JTAG flash programming port
`timescale 1ns/1ps
module fps_port_sva #(
  parameter logic [7:0] PROG_TICKS = 8'h04
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [fps_pkg::ADDR_W-1:0] flash_addr_o,
  input wire logic flash_read_strobe_o,
  input wire logic flash_oe_o,
  input wire logic flash_sense_en_o,
  input wire logic flash_prog_o,
  input wire logic flash_erase_o,
  input wire logic flash_erase_all_o
);
  logic [14:0] prog_addr_reg;
  logic [11:0] len_reg;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // Address at program start and length of the program cycle
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_addr_reg <= 15'h0000;
      len_reg <= 12'h000;
    end else begin
      if ($rose(flash_prog_o)) begin
        prog_addr_reg <= flash_addr_o;
      end
      len_reg <= flash_prog_o ? len_reg + 12'h001 : 12'h000;
    end
  end
  a_prog_min_len: assert property ($fell(flash_prog_o) |-> len_reg >= {4'h0, PROG_TICKS})
    else $error("program cycle shorter than its tick count");
  a_prog_addr_step: assert property ($fell(flash_prog_o) |-> ##[0:2]
    flash_addr_o == prog_addr_reg + 15'h0001) else $error("address did not step");
  a_erase_addr_kept: assert property (flash_erase_o |=> $stable(flash_addr_o))
    else $error("address moved during erase");
  a_erase_all_hit: assert property ($rose(flash_erase_o) && flash_addr_o[14:1] == 14'h3EFF
    |-> ##[0:1] flash_erase_all_o) else $error("top user address did not erase all");
  a_strobe_width: assert property ($rose(flash_read_strobe_o) |-> ##[1:2]
    !flash_read_strobe_o) else $error("read strobe too long");
  a_strobe_enables: assert property (flash_read_strobe_o |-> flash_oe_o && flash_sense_en_o)
    else $error("strobe without enables");
  a_enables_paired: assert property (flash_oe_o == flash_sense_en_o)
    else $error("output and sense enables differ");
  a_single_action: assert property ($onehot0({flash_read_strobe_o, flash_prog_o, flash_erase_o}))
    else $error("two flash actions at once");
  c_program: cover property ($fell(flash_prog_o));
  c_erase_all: cover property (flash_erase_all_o);
  c_long_strobe: cover property ($rose(flash_read_strobe_o) ##1 flash_read_strobe_o);
endmodule
bind fps_jtag_flash_port fps_port_sva #(.PROG_TICKS(PROG_TICKS)) fps_port_sva_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .flash_addr_o(flash_addr_o),
  .flash_read_strobe_o(flash_read_strobe_o), .flash_oe_o(flash_oe_o),
  .flash_sense_en_o(flash_sense_en_o), .flash_prog_o(flash_prog_o),
  .flash_erase_o(flash_erase_o), .flash_erase_all_o(flash_erase_all_o));

// file: sim/fps_flash_model.sv
// Behavioural flash array on the far side of the sequencer
`timescale 1ns/1ps
module fps_flash_model (
  input wire logic clock_i,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic oe_i,
  input wire logic prog_i,
  input wire logic erase_i,
  input wire logic erase_all_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:32767];
  logic [7:0] junk_reg = 8'h00;
  logic act_reg = 1'b0;
  // Blank array reads all ones
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hFF;
    end
  end
  // Act on the first clock of a cycle; reserved area from 7E00 never erased
  always @(posedge clock_i) begin
    act_reg <= prog_i || erase_i;
    junk_reg <= ~junk_reg;
    if (prog_i && !act_reg) begin
      mem[addr_i] <= wdata_i;
    end
    if (erase_i && !act_reg) begin
      for (int i = 0; i < 32256; i++) begin
        if (erase_all_i || i[14:9] == addr_i[14:9]) begin
          mem[i] <= 8'hFF;
        end
      end
    end
  end
  // Released bus shows a changing pattern, not stale data
  assign rdata_o = oe_i ? mem[addr_i] : junk_reg;
endmodule

// file: sim/tb.sv
// Testbench: JTAG host tasks driving the flash programming port
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  import fps_pkg::*;
  localparam logic [3:0] CTL = IR_SEL_CONTROL;
  localparam logic [3:0] ADR = IR_SEL_ADDRESS;
  localparam logic [3:0] DAT = IR_SEL_DATA;
  localparam logic [3:0] SCL = IR_SEL_SCALE;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b0;
  logic locked = 1'b0;
  logic tdo, tdo_oe, oe_seen, strobe, oe, sense, prog, erase, erase_all;
  logic [7:0] rdata, wdata;
  logic [14:0] addr;
  logic [17:0] v;
  logic [19:0] q;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_strobe = 0, n_prog = 0, n_erase = 0, n_all = 0, s0, strobe_w;
  realtime t_rise;
  fps_jtag_flash_port #(.PROG_TICKS(8'h02), .ERASE_TICKS(8'h03)) fps_jtag_flash_port_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .flash_rdata_i(rdata), .flash_locked_i(locked),
    .flash_addr_o(addr), .flash_wdata_o(wdata), .flash_read_strobe_o(strobe),
    .flash_oe_o(oe), .flash_sense_en_o(sense), .flash_prog_o(prog),
    .flash_erase_o(erase), .flash_erase_all_o(erase_all));
  fps_flash_model fps_flash_model_inst (.clock_i(clock_i), .addr_i(addr), .wdata_i(wdata),
    .oe_i(oe), .prog_i(prog), .erase_i(erase), .erase_all_i(erase_all), .rdata_o(rdata));
  always #20 clock_i = ~clock_i;
  // Count flash actions; strobe width in system clocks
  always @(posedge strobe) begin
    n_strobe++;
    t_rise = $realtime;
  end
  always @(negedge strobe) strobe_w = int'(($realtime - t_rise) / 40.0);
  always @(posedge prog) n_prog++;
  always @(posedge erase) n_erase++;
  always @(posedge erase_all) n_all++;
  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One test clock, 12 ns; clock stands low between frames
  task automatic tk(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #3 o = tdo;
    #3 tck = 1'b1;
    #6 tck = 1'b0;
  endtask
  task automatic ir_set(input logic [3:0] c);
    logic o;
    tk(1, 0, o);
    tk(1, 0, o);
    tk(0, 0, o);
    tk(0, 0, o);
    for (int i = 0; i < 4; i++) tk(i == 3, c[i], o);
    tk(1, 0, o);
    tk(0, 0, o);
  endtask
  // Shift n bits into the top of the word; first bits out are bit 0 upward
  task automatic dr(input int n, input logic [19:0] w, output logic [19:0] r);
    logic o;
    r = '0;
    tk(1, 0, o);
    tk(0, 0, o);
    tk(0, 0, o);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, w[20-n+i], o);
      r[i] = o;
      if (i == 0) oe_seen = tdo_oe;
    end
    tk(1, 0, o);
    tk(0, 0, o);
  endtask
  // Single-bit polls until busy drops; bounded
  task automatic wt();
    logic [19:0] r;
    for (int k = 0; k < 100; k++) begin
      dr(1, 20'h0, r);
      if (r[0] === 1'b0) return;
    end
    n_mismatch++;
    wrap_up();
  endtask
  task automatic wr(input logic [3:0] r, input logic [17:0] d);
    ir_set(r);
    dr(20, {2'b11, d}, q);
    wt();
  endtask
  task automatic w8(input logic [3:0] r, input logic [7:0] b);
    wr(r, {b, 10'h000});
  endtask
  task automatic rd(input logic [3:0] r, output logic [17:0] d);
    ir_set(r);
    dr(20, {2'b10, 18'h0}, q);
    wt();
    dr(20, 20'h0, q);
    d = q[18:1];
    `CHK("tdo enable", 2'b10, {oe_seen, tdo_oe})
  endtask
  initial begin
    logic o;
    // Clock the TAP during reset so its flops leave the unknown state
    repeat (2) tk(1, 0, o);
    repeat (12) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clock_i);
    tk(0, 0, o);
    rd(CTL, v);
    `CHK("control", 18'h0, v)
    rd(SCL, v);
    `CHK("scale", 18'h0, v)
    rd(DAT, v);
    `CHK("data", 18'h0, v)
    w8(DAT, 8'h3C);
    rd(DAT, v);
    `CHK("plain data", {8'h0, 8'h3C, 2'b00}, v)
    `CHK("no action", 0, n_prog + n_strobe)
    w8(CTL, 8'h10);
    wr(ADR, {15'h0010, 3'h0});
    w8(DAT, 8'h5A);
    w8(SCL, 8'hFF);
    rd(SCL, v);
    `CHK("scale mask", 18'h000CF, v)
    w8(DAT, 8'h44);
    rd(DAT, v);
    `CHK("refused", {8'h0, 8'h44, 2'b10}, v)
    w8(SCL, 8'h00);
    w8(DAT, 8'hC3);
    rd(DAT, v);
    `CHK("programmed", {8'h0, 8'hC3, 2'b00}, v)
    rd(ADR, v);
    `CHK("address", 18'h00012, v)
    @(negedge clock_i) locked = 1'b1;
    w8(DAT, 8'h99);
    rd(DAT, v);
    `CHK("locked", {8'h0, 8'h99, 2'b10}, v)
    `CHK("programs", 2, n_prog)
    @(negedge clock_i) locked = 1'b0;
    // Second command lands while busy; slow prescale keeps it busy
    w8(SCL, 8'h02);
    wr(ADR, {15'h0030, 3'h0});
    ir_set(DAT);
    dr(20, {2'b11, 8'h11, 10'h0}, q);
    dr(10, {2'b11, 8'h22, 10'h0}, q);
    wt();
    rd(DAT, v);
    `CHK("busy drop", {8'h0, 8'h11, 2'b00}, v)
    `CHK("one program", 3, n_prog)
    ir_set(CTL);
    dr(20, {2'b01, 18'h3FFFF}, q);
    rd(CTL, v);
    `CHK("poll", 18'h00010, v)
    w8(SCL, 8'h00);
    w8(CTL, 8'h01);
    wr(ADR, {15'h0010, 3'h0});
    s0 = n_strobe;
    rd(DAT, v);
    rd(DAT, v);
    `CHK("block 1", 8'h5A, v[9:2])
    rd(DAT, v);
    `CHK("block 2", 8'hC3, v[9:2])
    `CHK("strobes", s0 + 3, n_strobe)
    `CHK("strobe width", 1, strobe_w)
    w8(SCL, 8'h80);
    rd(DAT, v);
    `CHK("one shot", 2, strobe_w)
    w8(CTL, 8'h02);
    s0 = n_strobe;
    rd(DAT, v);
    `CHK("unread", s0, n_strobe)
    rd(DAT, v);
    `CHK("single", s0 + 1, n_strobe)
    w8(SCL, 8'h40);
    `CHK("read always", 2'b11, {oe, sense})
    w8(SCL, 8'h00);
    `CHK("read idle", 2'b00, {oe, sense})
    w8(CTL, 8'h20);
    wr(ADR, {15'h0100, 3'h0});
    w8(DAT, 8'h11);
    `CHK("no key", 0, n_erase)
    w8(DAT, ERASE_KEY);
    rd(ADR, v);
    `CHK("erase addr", 18'h00100, v)
    `CHK("page erase", 1, n_erase)
    `CHK("not all", 0, n_all)
    wr(ADR, {ERASE_ALL_HI, 3'h0});
    w8(DAT, ERASE_KEY);
    `CHK("erase all", 1, n_all)
    wrap_up();
  end
endmodule
